// ### rtl/gci_mgmt_pkg.sv
// Constants and types shared by the GCI management channel controllers
package gci_mgmt_pkg;

    // Dual-ported memory locations
    localparam logic [11:0] MON_RX_OFS = 12'h73a;
    localparam logic [11:0] MON_TX_OFS = 12'h73c;
    localparam logic [11:0] CI_RX_OFS = 12'h73e;
    localparam logic [11:0] CI_TX_OFS = 12'h740;
    localparam logic [11:0] MODE_OFS = 12'h8b0;

    // Mode register layout; only the low five bits steer these channels
    localparam logic [15:0] MODE_RESET = 16'h3500;
    localparam int MODE_CHAN1_EN = 0;
    localparam int MODE_CHAN2_EN = 1;
    localparam int MODE_LOOPBACK = 2;
    localparam int MODE_PROTOCOL = 4;

    // Descriptor layout
    localparam int DESC_FLAG = 15;
    localparam int DESC_LAST = 14;
    localparam int DESC_ERROR = 13;
    localparam int DESC_MISMATCH = 12;
    localparam int DESC_ABIT = 9;
    localparam int DESC_EBIT = 8;
    localparam int DESC_CI_LSB = 2;

    // Frame word, first bit on the wire at the top
    localparam int FRAME_BITS = 32;
    localparam logic [4:0] FRAME_LAST_POS = 5'h1f;
    localparam int SLOT_MON_LSB = 8;
    localparam int SLOT_CI_LSB = 2;
    localparam int SLOT_ABIT = 1;
    localparam int SLOT_EBIT = 0;

    // Frames that the A bit is held active for an abort request
    localparam logic [1:0] ABORT_FRAMES = 2'h2;

    // Part revision shown after reset; value is arbitrary
    localparam logic [15:0] PART_REVISION = 16'h0001;

    localparam int FIFO_DEPTH = 4;

    typedef struct packed {
        logic [7:0] mon;
        logic a_bit;
        logic e_bit;
        logic [3:0] ci;
    } gci_frame_type;

    typedef enum logic [1:0] {
        MTX_IDLE,
        MTX_SEND,
        MTX_EOM
    } mon_tx_state_type;

endpackage

// ### rtl/gci_monitor_ci_channel_ctrl.sv
// GCI monitor and command/indication channel controllers with frame FIFO
// How it works
// - Low five mode bits steer both channels
// - Protocol select runs monitor handshake internally
// - Loopback returns sent frames; each channel needs its own enable
// - Abort command signals abort on A bit
// - Timeout command signals end-of-message on E bit
// - Monitor receive word: flags, A, E, data
// - Empty gates acknowledge or discards new bytes
// - E end-of-message sets last flag
// - Unacknowledged new byte sets error and last
// - Two identical receptions before storing; mismatch flag
// - Ready cleared after send, or after acknowledge
// - Without ready the previous byte is resent
// - Last flag sends byte then end-of-message
// - Received abort sets flag, sends end-of-message
// - Transparent mode sends descriptor A, E, data
// - C/I receive word: empty, code, zero bits
// - Further C/I codes dropped until empty set
// - C/I ready cleared after transmission
// - Per-channel requests on fill or empty
// - Revision readable until first receive write
// - C/I code valid after two equal frames
// - Transparent resend keeps previous A and E
`timescale 1ns/1ps

module gci_frame_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [CNT_W-1:0] count;
    } fifo_state_type;

    fifo_state_type s;
    fifo_state_type next_s;
    logic push;
    logic pop;

    assign in_ready_out = (s.count != CNT_W'(DEPTH));
    assign out_valid_out = (s.count != '0);
    assign out_data_out = s.mem[s.rd_ptr];
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    always_comb
    begin
        next_s = s;
        if (push)
        begin
            next_s.mem[s.wr_ptr] = in_data_in;
            next_s.wr_ptr = (s.wr_ptr == PTR_W'(DEPTH - 1)) ? '0
                : s.wr_ptr + 1'b1;
        end
        if (pop)
        begin
            next_s.rd_ptr = (s.rd_ptr == PTR_W'(DEPTH - 1)) ? '0
                : s.rd_ptr + 1'b1;
        end
        if (push && !pop)
        begin
            next_s.count = s.count + 1'b1;
        end
        else if (pop && !push)
        begin
            next_s.count = s.count - 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end
endmodule // gci_frame_fifo

module gci_monitor_ci_channel_ctrl #(
    parameter logic [15:0] REVISION = gci_mgmt_pkg::PART_REVISION
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [11:0] host_addr_in,
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire logic [15:0] host_wdata_in,
    output logic [15:0] host_rdata_out,
    input wire logic gci_mode_in,
    input wire logic abort_request_cmd_in,
    input wire logic stall_timeout_cmd_in,
    input wire logic dcl_in,
    input wire logic fsc_in,
    input wire logic dd_in,
    output logic du_out,
    output logic du_oe_n_out,
    output logic mon_irq_out,
    output logic ci_irq_out
);
    typedef struct packed {
        logic [2:0] dcl_sync;
        logic [1:0] fsc_sync;
        logic [1:0] dd_sync;
        logic fsc_seen;
        logic [4:0] bit_pos;
        logic [31:0] rx_shift;
        logic [31:0] tx_shift;
        gci_mgmt_pkg::gci_frame_type tx_snap;
        logic push_valid;
        gci_mgmt_pkg::gci_frame_type push_frame;
        logic [15:0] mode;
        logic [15:0] mon_rx;
        logic [15:0] mon_tx;
        logic [15:0] ci_rx;
        logic [15:0] ci_tx;
        gci_mgmt_pkg::mon_tx_state_type mtx;
        logic mon_sent;
        logic ci_sent;
        logic [7:0] rx_prev;
        logic rx_prev_valid;
        logic rx_active;
        logic captured;
        logic ack_pending;
        logic a_prev;
        logic [1:0] abort_frames;
        logic [3:0] ci_prev;
        logic [3:0] ci_valid;
        logic [15:0] rdata;
        logic du;
        logic du_oe_n;
        logic mon_irq;
        logic ci_irq;
    } ctrl_state_type;

    ctrl_state_type s;
    ctrl_state_type next_s;
    gci_mgmt_pkg::gci_frame_type fifo_out;
    gci_mgmt_pkg::gci_frame_type f;
    gci_mgmt_pkg::gci_frame_type rx_frame;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic drain;
    logic chan1_en;
    logic chan2_en;
    logic proto;
    logic a_active;
    logic [31:0] tx_word;
    logic [31:0] rx_word;

    // Upper eleven mode bits are stored but never read here
    assign chan1_en = s.mode[gci_mgmt_pkg::MODE_CHAN1_EN];
    assign chan2_en = s.mode[gci_mgmt_pkg::MODE_CHAN2_EN];
    assign proto = s.mode[gci_mgmt_pkg::MODE_PROTOCOL];

    // Draining pauses during host writes so hardware and host never
    // update a descriptor in the same cycle
    assign drain = fifo_out_valid & ~host_wr_in;
    assign f = fifo_out;

    // Acknowledge withheld until the host has emptied the descriptor
    assign a_active = (s.ack_pending & s.mon_rx[gci_mgmt_pkg::DESC_FLAG])
        | (s.abort_frames != '0);

    // The push edge also samples the last bit, so that bit is joined here
    assign rx_word = {s.rx_shift[30:0], s.dd_sync[1]};
    assign rx_frame.mon = rx_word[gci_mgmt_pkg::SLOT_MON_LSB +: 8];
    assign rx_frame.a_bit = rx_word[gci_mgmt_pkg::SLOT_ABIT];
    assign rx_frame.e_bit = rx_word[gci_mgmt_pkg::SLOT_EBIT];
    assign rx_frame.ci = rx_word[gci_mgmt_pkg::SLOT_CI_LSB +: 4];

    gci_frame_fifo #(
        .WIDTH($bits(gci_mgmt_pkg::gci_frame_type)),
        .DEPTH(gci_mgmt_pkg::FIFO_DEPTH)
    ) frame_fifo (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .in_valid_in(s.push_valid),
        .in_ready_out(fifo_in_ready),
        .in_data_in(s.push_frame),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(~host_wr_in),
        .out_data_out(fifo_out)
    );

    // Outgoing frame; released slots stay high on the open-drain line
    always_comb
    begin
        tx_word = '1;
        if (chan1_en)
        begin
            tx_word[gci_mgmt_pkg::SLOT_MON_LSB +: 8] = s.mon_tx[7:0];
            if (!proto)
            begin
                tx_word[gci_mgmt_pkg::SLOT_ABIT] =
                    s.mon_tx[gci_mgmt_pkg::DESC_ABIT];
                tx_word[gci_mgmt_pkg::SLOT_EBIT] =
                    s.mon_tx[gci_mgmt_pkg::DESC_EBIT];
            end
            else
            begin
                tx_word[gci_mgmt_pkg::SLOT_ABIT] = ~a_active;
                tx_word[gci_mgmt_pkg::SLOT_EBIT] =
                    (s.mtx != gci_mgmt_pkg::MTX_SEND);
            end
        end
        if (chan2_en)
        begin
            tx_word[gci_mgmt_pkg::SLOT_CI_LSB +: 4] =
                s.ci_tx[gci_mgmt_pkg::DESC_CI_LSB +: 4];
        end
    end

    always_comb
    begin
        next_s = s;
        next_s.dcl_sync = {s.dcl_sync[1:0], dcl_in};
        next_s.fsc_sync = {s.fsc_sync[0], fsc_in};
        next_s.dd_sync = {s.dd_sync[0], dd_in};
        next_s.mon_irq = 1'b0;
        next_s.ci_irq = 1'b0;
        if (fifo_in_ready)
        begin
            next_s.push_valid = 1'b0;
        end

        // Rising line clock: frame start on a new sync, else next bit
        if (s.dcl_sync[1] && !s.dcl_sync[2])
        begin
            next_s.fsc_seen = s.fsc_sync[1];
            if (s.fsc_sync[1] && !s.fsc_seen)
            begin
                next_s.bit_pos = '0;
                next_s.tx_shift = tx_word;
                next_s.tx_snap.mon = tx_word[gci_mgmt_pkg::SLOT_MON_LSB +: 8];
                next_s.tx_snap.a_bit = tx_word[gci_mgmt_pkg::SLOT_ABIT];
                next_s.tx_snap.e_bit = tx_word[gci_mgmt_pkg::SLOT_EBIT];
                next_s.tx_snap.ci = tx_word[gci_mgmt_pkg::SLOT_CI_LSB +: 4];
                next_s.mon_sent = s.mon_tx[gci_mgmt_pkg::DESC_FLAG]
                    & chan1_en
                    & (!proto || s.mtx == gci_mgmt_pkg::MTX_SEND);
                next_s.ci_sent = s.ci_tx[gci_mgmt_pkg::DESC_FLAG] & chan2_en;
                if (s.ack_pending && s.mon_rx[gci_mgmt_pkg::DESC_FLAG])
                begin
                    next_s.ack_pending = 1'b0;
                end
                if (s.abort_frames != '0)
                begin
                    next_s.abort_frames = s.abort_frames - 1'b1;
                end
                next_s.du = tx_word[gci_mgmt_pkg::FRAME_BITS - 1];
            end
            else
            begin
                next_s.bit_pos = s.bit_pos + 1'b1;
                next_s.tx_shift = {s.tx_shift[30:0], 1'b1};
                next_s.du = s.tx_shift[gci_mgmt_pkg::FRAME_BITS - 2];
            end
            next_s.du_oe_n = next_s.du;
        end

        // Falling line clock: sample; a whole frame goes to the FIFO
        if (!s.dcl_sync[1] && s.dcl_sync[2])
        begin
            next_s.rx_shift = {s.rx_shift[30:0], s.dd_sync[1]};
            if (s.bit_pos == gci_mgmt_pkg::FRAME_LAST_POS)
            begin
                // A frame left unaccepted by a full FIFO is overwritten
                next_s.push_valid = 1'b1;
                next_s.push_frame = s.mode[gci_mgmt_pkg::MODE_LOOPBACK]
                    ? s.tx_snap : rx_frame;
            end
        end

        if (drain && chan1_en && !proto)
        begin
            if (s.mon_rx[gci_mgmt_pkg::DESC_FLAG])
            begin
                next_s.mon_rx = {4'h0, 2'h0, f.a_bit, f.e_bit,
                    f.mon};
                next_s.mon_irq = 1'b1;
            end
            if (s.mon_sent)
            begin
                next_s.mon_tx[gci_mgmt_pkg::DESC_FLAG] = 1'b0;
                next_s.mon_sent = 1'b0;
                next_s.mon_irq = 1'b1;
            end
        end

        if (drain && chan1_en && proto)
        begin
            next_s.a_prev = f.a_bit;
            case (s.mtx)
                gci_mgmt_pkg::MTX_IDLE:
                begin
                    if (s.mon_tx[gci_mgmt_pkg::DESC_FLAG])
                    begin
                        next_s.mtx = gci_mgmt_pkg::MTX_SEND;
                    end
                end
                gci_mgmt_pkg::MTX_SEND:
                begin
                    if (!f.a_bit && !s.a_prev)
                    begin
                        next_s.mon_tx[gci_mgmt_pkg::DESC_ERROR] =
                            1'b1;
                        next_s.mtx = gci_mgmt_pkg::MTX_EOM;
                        next_s.mon_sent = 1'b0;
                    end
                    else if (s.mon_sent && !f.a_bit)
                    begin
                        next_s.mon_tx[gci_mgmt_pkg::DESC_FLAG] = 1'b0;
                        next_s.mon_sent = 1'b0;
                        next_s.mon_irq = 1'b1;
                        if (s.mon_tx[gci_mgmt_pkg::DESC_LAST])
                        begin
                            next_s.mtx = gci_mgmt_pkg::MTX_EOM;
                        end
                    end
                end
                gci_mgmt_pkg::MTX_EOM:
                begin
                    next_s.mtx = gci_mgmt_pkg::MTX_IDLE;
                end
                default:
                begin
                    next_s.mtx = gci_mgmt_pkg::MTX_IDLE;
                end
            endcase

            if (!f.e_bit)
            begin
                next_s.rx_active = 1'b1;
                next_s.rx_prev = f.mon;
                next_s.rx_prev_valid = 1'b1;
                if (s.rx_prev_valid && f.mon == s.rx_prev)
                begin
                    next_s.mon_rx[gci_mgmt_pkg::DESC_MISMATCH] = 1'b0;
                    if (!s.captured && s.ack_pending
                        && f.mon != s.mon_rx[7:0])
                    begin
                        next_s.mon_rx[gci_mgmt_pkg::DESC_LAST] =
                            1'b1;
                        next_s.mon_rx[gci_mgmt_pkg::DESC_ERROR] =
                            1'b1;
                        next_s.mon_rx[gci_mgmt_pkg::DESC_FLAG] = 1'b0;
                        next_s.captured = 1'b1;
                        next_s.mon_irq = 1'b1;
                    end
                    else if (!s.captured && s.mon_rx[gci_mgmt_pkg::DESC_FLAG])
                    begin
                        next_s.mon_rx = {8'h00, f.mon};
                        next_s.captured = 1'b1;
                        next_s.ack_pending = 1'b1;
                        next_s.mon_irq = 1'b1;
                    end
                end
                else if (s.rx_prev_valid)
                begin
                    next_s.mon_rx[gci_mgmt_pkg::DESC_MISMATCH] = 1'b1;
                    next_s.captured = 1'b0;
                end
            end
            else if (s.rx_active)
            begin
                next_s.mon_rx[gci_mgmt_pkg::DESC_LAST] = 1'b1;
                next_s.mon_rx[gci_mgmt_pkg::DESC_FLAG] = 1'b0;
                next_s.mon_irq = 1'b1;
                next_s.rx_active = 1'b0;
                next_s.rx_prev_valid = 1'b0;
                next_s.captured = 1'b0;
            end
        end

        if (drain && chan2_en)
        begin
            next_s.ci_prev = f.ci;
            if (f.ci == s.ci_prev && f.ci != s.ci_valid)
            begin
                next_s.ci_valid = f.ci;
                if (s.ci_rx[gci_mgmt_pkg::DESC_FLAG])
                begin
                    next_s.ci_rx = {10'h000, f.ci, 2'h0};
                    next_s.ci_irq = 1'b1;
                end
            end
            if (s.ci_sent)
            begin
                next_s.ci_tx[gci_mgmt_pkg::DESC_FLAG] = 1'b0;
                next_s.ci_sent = 1'b0;
                next_s.ci_irq = 1'b1;
            end
        end

        // Commands only mean something with the handshake running
        if (gci_mode_in && proto && chan1_en)
        begin
            if (abort_request_cmd_in)
            begin
                next_s.abort_frames = gci_mgmt_pkg::ABORT_FRAMES;
                next_s.ack_pending = 1'b0;
            end
            if (stall_timeout_cmd_in)
            begin
                next_s.mtx = gci_mgmt_pkg::MTX_EOM;
                next_s.mon_sent = 1'b0;
            end
        end

        if (host_wr_in)
        begin
            case (host_addr_in)
                gci_mgmt_pkg::MON_RX_OFS: next_s.mon_rx = host_wdata_in;
                gci_mgmt_pkg::MON_TX_OFS:
                begin
                    next_s.mon_tx = host_wdata_in;
                    next_s.mon_sent = 1'b0;
                end
                gci_mgmt_pkg::CI_RX_OFS: next_s.ci_rx = host_wdata_in;
                gci_mgmt_pkg::CI_TX_OFS:
                begin
                    next_s.ci_tx = host_wdata_in;
                    next_s.ci_sent = 1'b0;
                end
                gci_mgmt_pkg::MODE_OFS: next_s.mode = host_wdata_in;
                default: next_s.mode = s.mode;
            endcase
        end

        if (host_rd_in)
        begin
            case (host_addr_in)
                gci_mgmt_pkg::MON_RX_OFS: next_s.rdata = s.mon_rx;
                gci_mgmt_pkg::MON_TX_OFS: next_s.rdata = s.mon_tx;
                gci_mgmt_pkg::CI_RX_OFS: next_s.rdata = s.ci_rx;
                gci_mgmt_pkg::CI_TX_OFS: next_s.rdata = s.ci_tx;
                gci_mgmt_pkg::MODE_OFS: next_s.rdata = s.mode;
                default: next_s.rdata = '0;
            endcase
        end

        // Requests only while the owning channel is enabled
        next_s.mon_irq = next_s.mon_irq & chan1_en;
        next_s.ci_irq = next_s.ci_irq & chan2_en;
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s <= '0;
            s.mode <= gci_mgmt_pkg::MODE_RESET;
            s.mon_rx <= REVISION;
            s.rx_shift <= '1;
            s.tx_shift <= '1;
            s.du <= 1'b1;
            s.du_oe_n <= 1'b1;
            s.a_prev <= 1'b1;
            s.mtx <= gci_mgmt_pkg::MTX_IDLE;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign host_rdata_out = s.rdata;
    assign du_out = s.du;
    assign du_oe_n_out = s.du_oe_n;
    assign mon_irq_out = s.mon_irq;
    assign ci_irq_out = s.ci_irq;
endmodule // gci_monitor_ci_channel_ctrl

// ### testbench/gci_mgmt_chk.sv
// Concurrent checks on the GCI management channel controller ports
`timescale 1ns/1ps

module gci_mgmt_chk (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [11:0] host_addr_in,
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire logic [15:0] host_wdata_in,
    input wire logic [15:0] host_rdata_out,
    input wire logic dcl_in,
    input wire logic du_out,
    input wire logic du_oe_n_out,
    input wire logic mon_irq_out,
    input wire logic ci_irq_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    logic [15:0] mode_q;
    logic [8:0] off_cnt;
    logic [3:0] since_rise;
    // Mode shadow from host writes; the checker never trusts the read port
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mode_q <= gci_mgmt_pkg::MODE_RESET;
            off_cnt <= 9'h000;
            since_rise <= 4'hf;
        end
        else
        begin
            if (host_wr_in && host_addr_in == gci_mgmt_pkg::MODE_OFS)
                mode_q <= host_wdata_in;
            if (mode_q[1:0] != 2'h0)
                off_cnt <= 9'h000;
            else if (off_cnt != 9'h190)
                off_cnt <= off_cnt + 9'h001;
            if ($rose(dcl_in))
                since_rise <= 4'h0;
            else if (since_rise != 4'hf)
                since_rise <= since_rise + 4'h1;
        end
    end
    sequence s_mode_rd;
        host_rd_in && host_addr_in == gci_mgmt_pkg::MODE_OFS;
    endsequence
    sequence s_odd_rd;
        host_rd_in && !(host_addr_in inside {12'h73a, 12'h73c, 12'h73e,
            12'h740, 12'h8b0});
    endsequence
    a_mode_read: assert property (
        s_mode_rd |=> host_rdata_out == $past(mode_q))
        else $error("Mode word read back wrong");
    a_unmapped_zero: assert property (
        s_odd_rd |=> host_rdata_out == 16'h0)
        else $error("Unmapped read not zero");
    a_rdata_hold: assert property (
        !host_rd_in |=> $stable(host_rdata_out))
        else $error("Read data moved without a read");
    a_drive_low: assert property (!du_oe_n_out |-> !du_out)
        else $error("Line driven high");
    a_disabled_quiet: assert property (
        off_cnt == 9'h190 |-> du_oe_n_out)
        else $error("Line driven with both channels off");
    a_bit_timing: assert property ($changed(du_oe_n_out) |->
        since_rise inside {[1:6]})
        else $error("Line changed away from a line clock rise");
    a_mon_irq_pulse: assert property (mon_irq_out |=> !mon_irq_out)
        else $error("Monitor request longer than one cycle");
    a_ci_irq_pulse: assert property (ci_irq_out |=> !ci_irq_out)
        else $error("C/I request longer than one cycle");
    a_mon_irq_gate: assert property (mon_irq_out |-> mode_q[0])
        else $error("Monitor request while disabled");
    a_ci_irq_gate: assert property (ci_irq_out |-> mode_q[1])
        else $error("C/I request while disabled");
endmodule // gci_mgmt_chk

bind gci_monitor_ci_channel_ctrl gci_mgmt_chk chk_i (.clk_in(clk_in),
    .rst_in(rst_in), .host_addr_in(host_addr_in), .host_wr_in(host_wr_in),
    .host_rd_in(host_rd_in), .host_wdata_in(host_wdata_in),
    .host_rdata_out(host_rdata_out), .dcl_in(dcl_in), .du_out(du_out),
    .du_oe_n_out(du_oe_n_out), .mon_irq_out(mon_irq_out),
    .ci_irq_out(ci_irq_out));

// ### testbench/gci_xcvr_model.sv
// Behavioural layer-1 transceiver on the GCI frame bus
`timescale 1ns/1ps

module gci_xcvr_model (
    output logic dcl_out,
    output logic fsc_out,
    output logic dd_out,
    input wire logic du_in,
    input wire logic du_oe_n_in
);
    logic [7:0] mon = 8'hff;
    logic a_bit = 1'b1;
    logic e_bit = 1'b1;
    logic [3:0] ci = 4'hf;
    logic [31:0] cap = 32'hffffffff;
    logic [31:0] word;
    initial
    begin
        dcl_out = 1'b0;
        fsc_out = 1'b0;
        dd_out = 1'b1;
    end
    // Line clock only runs inside frames; idle slots float high by pull-up
    task automatic send(input int n);
        for (int f = 0; f < n; f++)
        begin
            word = {16'hffff, mon, 2'h3, ci, a_bit, e_bit};
            for (int i = 0; i < 32; i++)
            begin
                dd_out = word[31 - i];
                fsc_out = (i == 0);
                #10 dcl_out = 1'b1;
                #400 dcl_out = 1'b0;
                #390 cap = {cap[30:0], du_in | du_oe_n_in};
            end
        end
        dd_out = 1'b1;
        fsc_out = 1'b0;
        // Room for the frame to cross the FIFO and land
        #2000;
    endtask
endmodule // gci_xcvr_model

// ### testbench/testbench.sv
// Self-checking bench for the GCI management channel controller
`timescale 1ns/1ps

module testbench;
    localparam logic [15:0] REV = 16'h5a5a; // Arbitrary revision value
    logic clk_in;
    logic rst_in;
    logic [11:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic gci;
    logic abort;
    logic stall;
    logic dcl, fsc, dd, du, du_oe_n, mon_irq, ci_irq;
    int n_fail = 0;
    int check_count = 0;
    int n_mirq = 0;
    int n_cirq = 0;

    gci_monitor_ci_channel_ctrl #(.REVISION(REV)) uut (.clk_in(clk_in),
        .rst_in(rst_in), .host_addr_in(addr), .host_wr_in(wr),
        .host_rd_in(rd), .host_wdata_in(wdata), .host_rdata_out(rdata),
        .gci_mode_in(gci), .abort_request_cmd_in(abort),
        .stall_timeout_cmd_in(stall), .dcl_in(dcl), .fsc_in(fsc),
        .dd_in(dd), .du_out(du), .du_oe_n_out(du_oe_n),
        .mon_irq_out(mon_irq), .ci_irq_out(ci_irq));
    gci_xcvr_model xcvr (.dcl_out(dcl), .fsc_out(fsc), .dd_out(dd),
        .du_in(du), .du_oe_n_in(du_oe_n));

    initial
    begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        n_mirq += mon_irq;
        n_cirq += ci_irq;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr16(input logic [11:0] a, input logic [15:0] d);
        @(negedge clk_in);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk_in);
        wr = 1'b0;
    endtask
    task automatic rd16(input logic [11:0] a, input logic [15:0] m, e);
        @(negedge clk_in);
        addr = a;
        rd = 1'b1;
        @(negedge clk_in);
        rd = 1'b0;
        chk(rdata & m, e);
    endtask
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Whole run is near twenty frames; allow several times that
    initial
    begin
        #3000000;
        n_fail++;
        close_out;
    end

    initial
    begin
        rst_in = 1'b1;
        addr = 12'h000;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 16'h0000;
        gci = 1'b1;
        abort = 1'b0;
        stall = 1'b0;
        repeat (5) @(negedge clk_in);
        rst_in = 1'b0;
        rd16(gci_mgmt_pkg::MODE_OFS, 16'hffff, 16'h3500);
        rd16(gci_mgmt_pkg::MON_RX_OFS, 16'hffff, REV);
        rd16(12'h742, 16'hffff, 16'h0000);
        wr16(gci_mgmt_pkg::MODE_OFS, 16'hff80);
        rd16(gci_mgmt_pkg::MODE_OFS, 16'hffff, 16'hff80);
        xcvr.send(1);
        chk(xcvr.cap, 32'hffffffff);
        wr16(gci_mgmt_pkg::CI_RX_OFS, 16'h8000);
        wr16(gci_mgmt_pkg::MODE_OFS, 16'h0002);
        xcvr.ci = 4'h5;
        xcvr.send(1);
        rd16(gci_mgmt_pkg::CI_RX_OFS, 16'hffff, 16'h8000);
        xcvr.send(1);
        rd16(gci_mgmt_pkg::CI_RX_OFS, 16'hffff, 16'h0014);
        chk(n_cirq != 0, 1);
        xcvr.ci = 4'ha;
        xcvr.send(2);
        rd16(gci_mgmt_pkg::CI_RX_OFS, 16'hffff, 16'h0014);
        wr16(gci_mgmt_pkg::CI_TX_OFS, 16'h8024);
        xcvr.send(2);
        chk(xcvr.cap, 32'hffffffe7);
        rd16(gci_mgmt_pkg::CI_TX_OFS, 16'hffff, 16'h0024);
        wr16(gci_mgmt_pkg::CI_RX_OFS, 16'h8000);
        wr16(gci_mgmt_pkg::MODE_OFS, 16'h0007);
        xcvr.send(3);
        rd16(gci_mgmt_pkg::CI_RX_OFS, 16'hffff, 16'h0024);
        wr16(gci_mgmt_pkg::MODE_OFS, 16'h0003);
        wr16(gci_mgmt_pkg::MON_RX_OFS, 16'h8000);
        wr16(gci_mgmt_pkg::MON_TX_OFS, 16'h81a5);
        xcvr.mon = 8'h3c;
        xcvr.e_bit = 1'b0;
        xcvr.send(2);
        chk({xcvr.cap[15:8], xcvr.cap[1:0]}, 10'h295);
        rd16(gci_mgmt_pkg::MON_TX_OFS, 16'hffff, 16'h01a5);
        rd16(gci_mgmt_pkg::MON_RX_OFS, 16'hffff, 16'h023c);
        chk(n_mirq != 0, 1);
        xcvr.mon = 8'hc3;
        xcvr.send(1);
        rd16(gci_mgmt_pkg::MON_RX_OFS, 16'hffff, 16'h023c);
        chk({xcvr.cap[15:8], xcvr.cap[1:0]}, 10'h295);
        wr16(gci_mgmt_pkg::MODE_OFS, 16'h0013);
        wr16(gci_mgmt_pkg::MON_RX_OFS, 16'h8000);
        xcvr.mon = 8'h11;
        xcvr.send(1);
        xcvr.mon = 8'h22;
        xcvr.send(1);
        rd16(gci_mgmt_pkg::MON_RX_OFS, 16'hf000, 16'h9000);
        xcvr.send(1);
        rd16(gci_mgmt_pkg::MON_RX_OFS, 16'hfcff, 16'h0022);
        wr16(gci_mgmt_pkg::MON_RX_OFS, 16'h8000);
        xcvr.e_bit = 1'b1;
        xcvr.send(2);
        rd16(gci_mgmt_pkg::MON_RX_OFS, 16'hc000, 16'h4000);
        @(negedge clk_in);
        abort = 1'b1;
        @(negedge clk_in);
        abort = 1'b0;
        xcvr.send(1);
        chk(xcvr.cap[1], 1'b0);
        // Handshake send starts; a timeout outside GCI must be ignored
        wr16(gci_mgmt_pkg::MON_TX_OFS, 16'h8077);
        xcvr.send(1);
        gci = 1'b0;
        @(negedge clk_in);
        stall = 1'b1;
        @(negedge clk_in);
        stall = 1'b0;
        xcvr.send(1);
        chk(xcvr.cap[0], 1'b0);
        rd16(gci_mgmt_pkg::MON_TX_OFS, 16'h8000, 16'h8000);
        gci = 1'b1;
        @(negedge clk_in);
        stall = 1'b1;
        @(negedge clk_in);
        stall = 1'b0;
        xcvr.send(1);
        chk(xcvr.cap[0], 1'b1);
        close_out;
    end
endmodule // testbench
